// ==== core/dram_training_odt_logic.sv ====
// Command/address training, write leveling and termination control of the memory device
//
// Behaviour
// - Mode write 29H/A4H enters command/address training
// - Mode write 2AH/A8H exits command/address training
// - Entry/exit decode works before timing is adjusted
// - Phase one reflects bits 0-3,5-8 onto data
// - Write 30H/C0H selects phase two, bits 4,9
// - Unmapped data pins driven to valid level
// - Feature two bit 7 enters/leaves write leveling
// - Strobe rise samples clock onto its lane
// - Termination enabled by nonzero field, selects resistance
// - Bit 2 keeps termination during power-down
// - Termination follows pin directly, unclocked
// - Reads switch termination off, ignore pin
// - Training keeps termination off
// - Power-down windows disable and restore termination
// - Self-refresh windows disable and restore termination
// - Deep power-down disables termination throughout
// - Termination switches all pins of a group together
// - Leveling: strobe termination on, data off
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/10ps
module dram_training_odt_logic (
	input wire logic clk,                                  // System clock, 40 MHz
	input wire logic reset_n,                              // Async reset, active low
	input wire logic psel,                                 // APB select
	input wire logic penable,                              // APB access phase
	input wire logic pwrite,                               // APB write
	input wire logic [7:0] paddr,                          // APB byte address
	input wire logic [31:0] pwdata,                        // APB write data
	output logic [31:0] prdata,                            // APB read data
	output logic pready,                                   // APB ready
	output logic pslverr,                                  // APB error, unmapped address
	input wire logic link_ck,                              // Memory clock from controller
	input wire logic cs_n,                                 // Chip select, active low
	input wire logic [train_term_pkg::CA_W-1:0] command_address_pins, // Command/address
	input wire logic [train_term_pkg::LANES-1:0] dqs,      // Strobe per byte lane
	input wire logic on_die_termination,                   // Termination pin, unclocked
	input wire logic read_active,                          // Read or mode read in progress
	input wire logic pd_active,                            // Power-down entry registered
	input wire logic sr_active,                            // Self-refresh entry registered
	input wire logic dpd_active,                           // Deep power-down entry registered
	output logic [train_term_pkg::DQ_W-1:0] dq_out,        // Data pin drive value
	output logic [train_term_pkg::DQ_W-1:0] dq_oe,         // Data pin drive enable
	output train_term_pkg::term_t term_out                 // Termination switches
);
	import train_term_pkg::*;

	localparam int DIS_BOUND = TERM_DISABLE_CYCLES + 1;
	localparam int EN_BOUND = TERM_ENABLE_CYCLES + 1;

	logic [CA_W+LANES+1:0] sync_out;
	logic ck_s, ck_d, cs_n_s, mrw_pend, blocked, gate_dq, gate_dqs;
	logic [CA_W-1:0] ca_s, rise_ca, fall_ca;
	logic [LANES-1:0] dqs_s, dqs_d, wl_sample;
	train_state_t phase, next_phase;
	logic [7:0] feature_two_register;
	logic [TERM_CTRL_W-1:0] termination_control_register;
	mrw_t last_mrw;
	logic [WIN_W-1:0] wcnt;
	logic [1:0] rtt_q;
	logic [DQ_W-1:0] next_dq, train1, train2, wl_dq;
	logic [31:0] next_rdata;

	// Link clock, chip select, strobes and command/address pass two flip-flops; the termination pin does not
	sync_two_ff #(.WIDTH(CA_W + LANES + 2)) u_sync (
		.clk(clk),
		.reset_n(reset_n),
		.din({link_ck, cs_n, dqs, command_address_pins}),
		.dout(sync_out)
	);

	// Split synchronised pins and find clock and strobe edges
	wire ck_rise = ck_s & ~ck_d;
	wire ck_fall = ~ck_s & ck_d;
	wire [LANES-1:0] dqs_rise = dqs_s & ~dqs_d;
	assign ck_s = sync_out[CA_W+LANES+1];
	assign cs_n_s = sync_out[CA_W+LANES];
	assign dqs_s = sync_out[CA_W+LANES-1:CA_W];
	assign ca_s = sync_out[CA_W-1:0];

	// Entry/exit match on one edge alone, so edge skew cannot hide them
	wire cmd_rise = ck_rise & ~cs_n_s;
	wire entry_hit = cmd_rise & (ca_s == CA_ENTRY_PATTERN);
	wire exit_hit = cmd_rise & (ca_s == CA_EXIT_PATTERN);

	// Full mode write decode joins the rising and falling halves
	wire mrw_done = ck_fall & mrw_pend;
	wire [7:0] mrw_addr = {ca_s[1:0], rise_ca[CA_W-1:MRW_MA_LO]};
	wire [7:0] mrw_op = ca_s[CA_W-1:2];
	wire remap_hit = mrw_done & (mrw_addr == CA_TRAIN_REMAP_MA) & (mrw_op == CA_TRAIN_REMAP_OP);
	wire f2_hit = mrw_done & (mrw_addr == FEATURE_TWO_MA);
	wire tc_hit = mrw_done & (mrw_addr == TERM_CTRL_MA);

	// APB decode
	wire apb_access = psel & penable;
	wire apb_done = apb_access & pready;
	wire sel_f2 = (paddr == FEATURE_TWO_OFF);
	wire sel_tc = (paddr == TERM_CTRL_OFF);
	wire sel_st = (paddr == STATUS_OFF);
	wire sel_lm = (paddr == LAST_MRW_OFF);
	wire mapped = sel_f2 | sel_tc | sel_st | sel_lm;
	wire apb_wr_f2 = apb_done & pwrite & sel_f2;
	wire apb_wr_tc = apb_done & pwrite & sel_tc;

	wire train_active = (phase != TRAIN_OFF);
	wire wl_active = feature_two_register[WL_BIT];
	wire term_enabled = (termination_control_register[1:0] != 2'h0);
	wire off_req = sr_active | dpd_active |
		(pd_active & ~termination_control_register[TERM_PD_BIT]);
	wire [WIN_W-1:0] win_last = off_req ? WIN_W'(TERM_DISABLE_CYCLES - 1) :
		WIN_W'(TERM_ENABLE_CYCLES - 1);
	wire allow = term_enabled & ~read_active & ~train_active & ~blocked;

	assign next_rdata = sel_f2 ? {24'h0, feature_two_register} :
		sel_tc ? {29'h0, termination_control_register} :
		sel_st ? {26'h0, gate_dqs, gate_dq, blocked, wl_active, phase} :
		sel_lm ? {16'h0, last_mrw} : 32'h0;

	// Training phase sequence
	always_comb begin
		next_phase = phase;
		case (phase)
			TRAIN_OFF: if (entry_hit) next_phase = TRAIN_PHASE1;
			TRAIN_PHASE1: begin
				if (exit_hit) next_phase = TRAIN_OFF;
				else if (remap_hit) next_phase = TRAIN_PHASE2;
			end
			TRAIN_PHASE2: if (exit_hit) next_phase = TRAIN_OFF;
			default: next_phase = TRAIN_OFF;
		endcase
	end

	// Phase one map: even pin gets the rising sample, odd pin the falling
	genvar gi;
	generate
		for (gi = 0; gi < LANE_W; gi++) begin : g_map
			localparam int SRC = (gi < P2_BIT_A) ? gi : gi + 1;
			assign train1[2*gi] = rise_ca[SRC];
			assign train1[2*gi+1] = fall_ca[SRC];
		end
		for (gi = 0; gi < LANES; gi++) begin : g_lane
			assign wl_dq[gi*LANE_W +: LANE_W] = {LANE_W{wl_sample[gi]}};
		end
	endgenerate

	// Phase two uses four pins; the rest are held low, never floating
	assign train2 = DQ_W'(rise_ca[P2_BIT_A]) |
		(DQ_W'(fall_ca[P2_BIT_A]) << 1) |
		(DQ_W'(rise_ca[P2_BIT_B]) << P2_DQ_B) |
		(DQ_W'(fall_ca[P2_BIT_B]) << (P2_DQ_B + 1));
	assign next_dq = (phase == TRAIN_PHASE1) ? train1 :
		(phase == TRAIN_PHASE2) ? train2 :
		wl_active ? wl_dq : '0;

	// Clock and strobe edge history
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			ck_d <= 1'b0;
			dqs_d <= '0;
		end else begin
			ck_d <= ck_s;
			dqs_d <= dqs_s;
		end
	end

	// Capture both halves of each memory clock period
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rise_ca <= '0;
			fall_ca <= '0;
			mrw_pend <= 1'b0;
		end else begin
			if (ck_rise) rise_ca <= ca_s;
			if (ck_fall) fall_ca <= ca_s;
			if (ck_rise) mrw_pend <= ~cs_n_s & (ca_s[3:0] == MRW_OPCODE);
			else if (ck_fall) mrw_pend <= 1'b0;
		end
	end

	// Training phase register
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) phase <= TRAIN_OFF;
		else phase <= next_phase;
	end

	// Mode registers; a link mode write wins over an APB write in the same cycle
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			feature_two_register <= FEATURE_TWO_RESET;
			termination_control_register <= TERM_CTRL_RESET;
			last_mrw <= '0;
		end else begin
			if (f2_hit) feature_two_register <= mrw_op;
			else if (apb_wr_f2) feature_two_register <= pwdata[7:0];
			if (tc_hit) termination_control_register <= mrw_op[TERM_CTRL_W-1:0];
			else if (apb_wr_tc) termination_control_register <= pwdata[TERM_CTRL_W-1:0];
			if (mrw_done) last_mrw <= '{addr: mrw_addr, op: mrw_op};
		end
	end

	// Leveling: each strobe rise latches the memory clock level
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) wl_sample <= '0;
		else wl_sample <= (dqs_rise & {LANES{wl_active}} & {LANES{ck_s}}) |
			(~(dqs_rise & {LANES{wl_active}}) & wl_sample);
	end

	// Data pin drive; leveling data is undefined on entry, so zero is fine
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			dq_out <= '0;
			dq_oe <= '0;
		end else begin
			dq_out <= next_dq;
			dq_oe <= {DQ_W{train_active | wl_active}};
		end
	end

	// Disable/enable windows: the count restarts if the request turns back
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			blocked <= 1'b0;
			wcnt <= '0;
		end else if (off_req == blocked) begin
			wcnt <= '0;
		end else if (wcnt == win_last) begin
			blocked <= off_req;
			wcnt <= '0;
		end else begin
			wcnt <= wcnt + WIN_W'(1);
		end
	end

	// Gates are clocked, the pin itself is not; strobes keep theirs in leveling
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			gate_dq <= 1'b0;
			gate_dqs <= 1'b0;
			rtt_q <= 2'h0;
		end else begin
			gate_dq <= allow & ~wl_active;
			gate_dqs <= allow;
			rtt_q <= termination_control_register[1:0];
		end
	end

	// Pin acts straight through the gate, with no sampling on the clock
	// The struct has one driver, so no member is driven from two processes
	wire term_dq = gate_dq & on_die_termination;
	wire term_dqs = gate_dqs & on_die_termination;
	assign term_out = '{dq: term_dq, dqs: term_dqs, termination_resistance: rtt_q};

	// APB slave: one wait state, data loaded on the same edge as ready, write at completion
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
			prdata <= '0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_access & ~pready;
			if (apb_access & ~pready) begin
				prdata <= pwrite ? 32'h0 : next_rdata;
				pslverr <= ~mapped;
			end
		end
	end

	property p_entry;
		@(posedge clk) disable iff (!reset_n)
		(entry_hit && phase == TRAIN_OFF) |=> (phase == TRAIN_PHASE1);
	endproperty
	a_entry: assert property (p_entry) else $error("training entry missed");
	property p_exit;
		@(posedge clk) disable iff (!reset_n)
		(exit_hit && phase != TRAIN_OFF) |=> (phase == TRAIN_OFF) ##1 (dq_oe == '0 || wl_active);
	endproperty
	a_exit: assert property (p_exit) else $error("training exit missed");
	property p_remap;
		@(posedge clk) disable iff (!reset_n)
		(remap_hit && !exit_hit && phase == TRAIN_PHASE1) |=> (phase == TRAIN_PHASE2);
	endproperty
	a_remap: assert property (p_remap) else $error("phase two not taken");
	property p_phase1_map;
		@(posedge clk) disable iff (!reset_n)
		(ck_rise && phase == TRAIN_PHASE1 && next_phase == TRAIN_PHASE1) |->
			##2 (phase != TRAIN_PHASE1 || dq_out[2] == $past(ca_s[1], 2));
	endproperty
	a_phase1_map: assert property (p_phase1_map) else $error("bit one not on even pin");
	property p_unused_valid;
		@(posedge clk) disable iff (!reset_n)
		(phase == TRAIN_PHASE2) [*2] |-> (dq_oe == '1 && dq_out[7:2] == 6'h0);
	endproperty
	a_unused_valid: assert property (p_unused_valid) else $error("unused pin not driven");
	property p_wl_feedback;
		@(posedge clk) disable iff (!reset_n)
		(dqs_rise[0] && wl_active && phase == TRAIN_OFF) ##1 wl_active |->
			##1 (dq_out[7:0] == {8{$past(ck_s, 2)}});
	endproperty
	a_wl_feedback: assert property (p_wl_feedback) else $error("leveling feedback wrong");
	property p_train_off;
		@(posedge clk) disable iff (!reset_n)
		train_active |=> (!gate_dq && !gate_dqs);
	endproperty
	a_train_off: assert property (p_train_off) else $error("termination during training");
	property p_read_off;
		@(posedge clk) disable iff (!reset_n)
		read_active |=> (!term_out.dq && !term_out.dqs);
	endproperty
	a_read_off: assert property (p_read_off) else $error("termination during read");
	property p_field_zero;
		@(posedge clk) disable iff (!reset_n)
		!term_enabled |=> (!gate_dq && !gate_dqs && term_out.termination_resistance == 2'h0);
	endproperty
	a_field_zero: assert property (p_field_zero) else $error("termination while disabled");
	// A pending off request must block the gate within the window unless withdrawn
	property p_disable_window;
		@(posedge clk) disable iff (!reset_n)
		(off_req && !blocked) |-> ##[1:DIS_BOUND] (blocked || !off_req);
	endproperty
	a_disable_window: assert property (p_disable_window) else $error("disable window late");
	property p_enable_window;
		@(posedge clk) disable iff (!reset_n)
		(!off_req && blocked) |-> ##[1:EN_BOUND] (!blocked || off_req);
	endproperty
	a_enable_window: assert property (p_enable_window) else $error("enable window late");
	property p_wl_term;
		@(posedge clk) disable iff (!reset_n)
		(wl_active && allow) |=> (gate_dqs && !gate_dq);
	endproperty
	a_wl_term: assert property (p_wl_term) else $error("leveling termination wrong");
endmodule

// ==== core/sync_two_ff.sv ====
// Two-stage synchroniser for pins that arrive from outside the clock domain
`timescale 1ns/10ps
module sync_two_ff #(
	parameter int WIDTH = 1
) (
	input wire logic clk,                 // System clock
	input wire logic reset_n,             // Async reset, active low
	input wire logic [WIDTH-1:0] din,     // Asynchronous input
	output logic [WIDTH-1:0] dout         // Synchronised output
);
	logic [WIDTH-1:0] meta;

	// First stage is read only by the second
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

// ==== core/train_term_pkg.sv ====
// Shared constants, types and register map for the training and termination block
package train_term_pkg;
	// Clock and window timing
	localparam int CLK_PERIOD_PS = 25000;
	localparam int TERM_DISABLE_WINDOW_NS = 20;
	localparam int TERM_ENABLE_WINDOW_NS = 20;
	// Longest times round down, never below one cycle
	localparam int TERM_DISABLE_CYCLES = (TERM_DISABLE_WINDOW_NS * 1000 / CLK_PERIOD_PS < 1) ? 1 :
		TERM_DISABLE_WINDOW_NS * 1000 / CLK_PERIOD_PS;
	localparam int TERM_ENABLE_CYCLES = (TERM_ENABLE_WINDOW_NS * 1000 / CLK_PERIOD_PS < 1) ? 1 :
		TERM_ENABLE_WINDOW_NS * 1000 / CLK_PERIOD_PS;
	localparam int WIN_W = 8;

	// Pin widths
	localparam int CA_W = 10;
	localparam int DQ_W = 16;
	localparam int LANES = 2;
	localparam int LANE_W = 8;

	// Mode write addresses and operands
	localparam logic [7:0] CA_TRAIN_ENTRY_MA = 8'h29;
	localparam logic [7:0] CA_TRAIN_ENTRY_OP = 8'ha4;
	localparam logic [7:0] CA_TRAIN_EXIT_MA = 8'h2a;
	localparam logic [7:0] CA_TRAIN_EXIT_OP = 8'ha8;
	localparam logic [7:0] CA_TRAIN_REMAP_MA = 8'h30;
	localparam logic [7:0] CA_TRAIN_REMAP_OP = 8'hc0;
	localparam logic [7:0] FEATURE_TWO_MA = 8'h02;
	localparam logic [7:0] TERM_CTRL_MA = 8'h0b;

	// Mode write layout on the pins: low four pins low on the rising edge
	localparam logic [3:0] MRW_OPCODE = 4'h0;
	localparam int MRW_MA_LO = 4;
	localparam int WL_BIT = 7;
	localparam int TERM_PD_BIT = 2;
	localparam int TERM_CTRL_W = 3;

	// Pin patterns for entry and exit, identical on both edges
	localparam logic [9:0] CA_ENTRY_PATTERN = {CA_TRAIN_ENTRY_MA[5:0], MRW_OPCODE};
	localparam logic [9:0] CA_EXIT_PATTERN = {CA_TRAIN_EXIT_MA[5:0], MRW_OPCODE};

	// Phase two pin positions
	localparam int P2_BIT_A = 4;
	localparam int P2_BIT_B = 9;
	localparam int P2_DQ_B = 8;

	// Register map (APB byte addresses)
	localparam logic [7:0] FEATURE_TWO_OFF = 8'h00;
	localparam logic [7:0] TERM_CTRL_OFF = 8'h04;
	localparam logic [7:0] STATUS_OFF = 8'h08;
	localparam logic [7:0] LAST_MRW_OFF = 8'h0c;
	localparam logic [7:0] FEATURE_TWO_RESET = 8'h00;
	localparam logic [2:0] TERM_CTRL_RESET = 3'h0;

	typedef enum logic [1:0] {TRAIN_OFF, TRAIN_PHASE1, TRAIN_PHASE2} train_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] op;
	} mrw_t;

	typedef struct packed {
		logic dq;     // Data pins and the data-mask pin
		logic dqs;    // Both strobe pins of every lane
		logic [1:0] termination_resistance;
	} term_t;
endpackage

// ==== tb/ctrl_model.sv ====
// Behavioural memory controller: link clock, chip select, command/address and strobes
`timescale 1ns/10ps
module ctrl_model (
	output logic link_ck, // Memory clock, toggled in frames, parked at a level in strobe pulses
	output logic cs_n, // Chip select, active low
	output logic [9:0] ca, // Command/address pins
	output logic [1:0] dqs // Strobe per byte lane
);
	initial begin
		link_ck = 1'b0;
		cs_n = 1'b1;
		ca = 10'h000;
		dqs = 2'b00;
	end

	// One memory clock period of 305 ns; pins change mid-phase so both edges see settled values
	task automatic frame(input logic [9:0] r, input logic [9:0] f, input logic c);
		#5;
		cs_n = c;
		ca = r;
		#100 link_ck = 1'b1;
		#50 ca = f;
		#50 link_ck = 1'b0;
		#100 cs_n = 1'b1;
		ca = ~f; // Released pins show no stale value
	endtask

	// Mode write; only these are sent while leveling is active
	task automatic mode_write_command(input logic [7:0] a, input logic [7:0] op);
		frame({a[5:0], 4'h0}, {op, a[7:6]}, 1'b0);
	endtask

	// Strobe pulse with the clock parked at a level; strobes stay still in training frames
	task automatic strobe(input int lane, input logic lvl);
		#5;
		link_ck = lvl;
		#100 dqs[lane] = 1'b1;
		#100 dqs[lane] = 1'b0;
		#100 link_ck = 1'b0;
	endtask
endmodule

// ==== tb/dram_training_odt_logic_tb.sv ====
// Self-checking bench for training, leveling and termination control
`timescale 1ns/10ps
module dram_training_odt_logic_tb;
	import train_term_pkg::*;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic pready, pslverr, e;
	logic link_ck, cs_n;
	logic [9:0] ca;
	logic [1:0] dqs;
	logic pin = 1'b0;
	logic [3:0] hold = 4'h0; // {read, deep pd, self refresh, power-down}
	logic [15:0] dq_out, dq_oe;
	term_t term_out;
	int bad_count = 0;
	int comparisons = 0;
	int k;

	initial begin
		forever #12.5 clk = ~clk;
	end

	ctrl_model ctrl_model_inst (.link_ck(link_ck), .cs_n(cs_n), .ca(ca), .dqs(dqs));

	dram_training_odt_logic dram_training_odt_logic_inst (
		.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.link_ck(link_ck), .cs_n(cs_n), .command_address_pins(ca), .dqs(dqs),
		.on_die_termination(pin), .read_active(hold[3]), .pd_active(hold[0]),
		.sr_active(hold[1]), .dpd_active(hold[2]), .dq_out(dq_out), .dq_oe(dq_oe),
		.term_out(term_out)
	);

	task automatic close_out();
		if (bad_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		comparisons++;
		if (s !== x) begin
			bad_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// APB transfer held until pready is sampled high; a stuck slave counts as a mismatch
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) bad_count++;
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q & m, x);
	endtask

	// Expected reflection in the first training phase
	function automatic logic [15:0] map1(input logic [9:0] r, input logic [9:0] f);
		int s[8] = '{0, 1, 2, 3, 5, 6, 7, 8};
		logic [15:0] m;
		for (int i = 0; i < 8; i++) begin
			m[2*i] = r[s[i]];
			m[2*i+1] = f[s[i]];
		end
		return m;
	endfunction

	// Expected reflection in the second phase; unmapped pins read low
	function automatic logic [15:0] map2(input logic [9:0] r, input logic [9:0] f);
		logic [15:0] m;
		m = 16'h0000;
		m[1:0] = {f[4], r[4]};
		m[9:8] = {f[9], r[9]};
		return m;
	endfunction

	initial begin
		#2000000;
		bad_count++;
		close_out();
	end

	initial begin
		cyc(20);
		reset_n <= 1'b1;
		cyc(3);
		chk(32'(term_out), 32'h0);
		chk(32'(dq_oe), 32'h0);
		rd_chk(FEATURE_TWO_OFF, 32'hff, 32'(FEATURE_TWO_RESET));
		rd_chk(TERM_CTRL_OFF, 32'h7, 32'(TERM_CTRL_RESET));
		rd_chk(STATUS_OFF, 32'h3f, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		chk(32'(e), 32'h1);
		chk(q, 32'h0);
		apb(1'b1, STATUS_OFF, 32'hff);
		rd_chk(STATUS_OFF, 32'h3, 32'h0);
		// Every resistance code, then the pin acting without a clock edge
		pin <= 1'b1;
		for (k = 1; k < 4; k++) begin
			apb(1'b1, TERM_CTRL_OFF, 32'(k));
			cyc(3);
			chk(32'(term_out), 32'(4'hc | k));
		end
		@(posedge clk);
		pin <= 1'b0;
		#1 chk(32'(term_out), 32'h3);
		@(posedge clk);
		pin <= 1'b1;
		apb(1'b1, TERM_CTRL_OFF, 32'h0);
		cyc(3);
		chk(32'(term_out), 32'h0);
		apb(1'b1, TERM_CTRL_OFF, 32'h1);
		// Power-down, self refresh, deep power-down and reads each force termination off
		for (k = 0; k < 4; k++) begin
			hold <= 4'(1 << k);
			cyc(TERM_DISABLE_CYCLES + 2);
			chk({31'h0, term_out.dq | term_out.dqs}, 32'h0);
			cyc(8);
			chk({31'h0, term_out.dq | term_out.dqs}, 32'h0);
			hold <= 4'h0;
			cyc(TERM_ENABLE_CYCLES + 2);
			chk(32'(term_out), 32'hd);
		end
		apb(1'b1, TERM_CTRL_OFF, 32'h5);
		hold <= 4'h1;
		cyc(TERM_DISABLE_CYCLES + 4);
		chk(32'(term_out), 32'hd);
		hold <= 4'h0;
		// Training: entry, both phases, exit
		ctrl_model_inst.mode_write_command(CA_TRAIN_ENTRY_MA, CA_TRAIN_ENTRY_OP);
		cyc(4);
		rd_chk(STATUS_OFF, 32'h3, 32'h1);
		chk({30'h0, term_out.dq, term_out.dqs}, 32'h0);
		ctrl_model_inst.frame(10'h3a5, 10'h15a, 1'b1);
		cyc(4);
		chk(32'(dq_out), 32'(map1(10'h3a5, 10'h15a)));
		chk(32'(dq_oe), 32'hffff);
		ctrl_model_inst.frame(10'h0f3, 10'h30c, 1'b1);
		cyc(4);
		chk(32'(dq_out), 32'(map1(10'h0f3, 10'h30c)));
		ctrl_model_inst.mode_write_command(CA_TRAIN_REMAP_MA, CA_TRAIN_REMAP_OP);
		cyc(4);
		rd_chk(STATUS_OFF, 32'h3, 32'h2);
		ctrl_model_inst.frame(10'h210, 10'h3ef, 1'b1);
		cyc(4);
		chk(32'(dq_out), 32'(map2(10'h210, 10'h3ef)));
		chk(32'(dq_oe), 32'hffff);
		ctrl_model_inst.mode_write_command(CA_TRAIN_EXIT_MA, CA_TRAIN_EXIT_OP);
		cyc(4);
		rd_chk(STATUS_OFF, 32'h3, 32'h0);
		chk({30'h0, term_out.dq, term_out.dqs}, 32'h3);
		rd_chk(LAST_MRW_OFF, 32'hffff, {16'h0, CA_TRAIN_EXIT_MA, CA_TRAIN_EXIT_OP});
		// Leveling: each strobe samples the parked clock onto its own lane
		ctrl_model_inst.mode_write_command(FEATURE_TWO_MA, 8'h80);
		cyc(4);
		rd_chk(STATUS_OFF, 32'h4, 32'h4);
		chk({30'h0, term_out.dq, term_out.dqs}, 32'h1);
		ctrl_model_inst.strobe(0, 1'b1);
		cyc(3);
		chk(32'(dq_out[7:0]), 32'hff);
		ctrl_model_inst.strobe(1, 1'b0);
		cyc(3);
		chk(32'(dq_out), 32'h00ff);
		ctrl_model_inst.strobe(1, 1'b1);
		ctrl_model_inst.strobe(0, 1'b0);
		cyc(3);
		chk(32'(dq_out), 32'hff00);
		chk(32'(dq_oe), 32'hffff);
		apb(1'b1, FEATURE_TWO_OFF, 32'h0);
		cyc(3);
		rd_chk(STATUS_OFF, 32'h4, 32'h0);
		// Termination field written over the link rather than the register bus
		ctrl_model_inst.mode_write_command(TERM_CTRL_MA, 8'h06);
		cyc(4);
		rd_chk(TERM_CTRL_OFF, 32'h7, 32'h6);
		close_out();
	end
endmodule
